// >>> rtl/tccc_defs.vh
// register offsets, field positions and reset values for the capture/compare block
`ifndef TCCC_DEFS_VH
`define TCCC_DEFS_VH

// register byte offsets on the apb bus
`define TCCC_OFS_CTRL0 12'h000
`define TCCC_OFS_HI0 12'h004
`define TCCC_OFS_LO0 12'h008
`define TCCC_OFS_CTRL1 12'h00C
`define TCCC_OFS_HI1 12'h010
`define TCCC_OFS_LO1 12'h014
`define TCCC_OFS_STAT 12'h018

// channel control field positions
`define TCCC_B_OVT 0
`define TCCC_B_FULL 1
`define TCCC_B_ELSLO 2
`define TCCC_B_ELSHI 3
`define TCCC_B_MSA 4
`define TCCC_B_MSB 5
`define TCCC_B_IE 6
`define TCCC_B_FLAG 7

// reset value of each channel control register
`define TCCC_CTRL_RST 8'h00

// edge/level select encodings
`define TCCC_ELS_OFF 2'h0
`define TCCC_ELS_RISE 2'h1
`define TCCC_ELS_FALL 2'h2
`define TCCC_ELS_BOTH 2'h3

`endif

// >>> rtl/tccc_value_mem.v
// two-word channel value store with registered read data
`timescale 1ns/1ps
module tccc_value_mem
#(
   parameter DW = 16
)
(
   input wire pclk, // bus clock
   input wire [1:0] we, // per-word write enable
   input wire [DW-1:0] wd0, // write data word 0
   input wire [DW-1:0] wd1, // write data word 1
   output reg [DW-1:0] rd0, // registered word 0
   output reg [DW-1:0] rd1 // registered word 1
);

// ----------------------------------------------------------------
// storage
// ----------------------------------------------------------------
// no reset: contents are undefined after reset
reg [DW-1:0] mem_r [0:1];

// write and registered read, write-first so compare sees new value
always @(posedge pclk)
begin
   if (we[0])
   begin
      mem_r[0] <= wd0;
   end
   if (we[1])
   begin
      mem_r[1] <= wd1;
   end
   rd0 <= we[0] ? wd0 : mem_r[0];
   rd1 <= we[1] ? wd1 : mem_r[1];
end

endmodule

// >>> rtl/tccc_top.v
// two-channel timer capture/compare logic with apb register access
//
// Summary of operation
// [RULE1] halt and clear counter before mode change
// [RULE2] capture edge: 01 rise, 10 fall, 11 both
// [RULE3] compare action: 01 toggle, 10 clear, 11 set
// [RULE4] select 00 frees pin, presets output level
// [RULE5] preset state drives pin once enabled
// [RULE6] reset clears edge/level select bits
// [RULE7] input stable two clocks before capture enable
// [RULE8] overflow toggle bit toggles pin on overflow
// [RULE9] overflow toggle ignored in capture, reset clears
// [RULE10] overflow wins over same-cycle compare match
// [RULE11] full-duty force gives 100 percent pwm
// [RULE12] full-duty change applies from next period
// [RULE13] 16-bit value register, rw, no reset
// [RULE14] high read blocks capture until low read
// [RULE15] high write blocks compare until low write
// [RULE16] event flag on capture or match
// [RULE17] flag cleared by read then write zero
// [RULE18] buffered bit links channels, frees pin 1
// [RULE19] mode bit a: capture or compare
// [RULE20] full-duty ignored when overflow toggle clear
//
// Implementation choices: the register addresses and the APB register port.
`timescale 1ns/1ps
`include "tccc_defs.vh"
module tccc_top
#(
   parameter CW = 16
)
(
   input wire pclk, // bus clock, 100 mhz
   input wire presetn, // async reset, active low
   input wire psel, // apb select
   input wire penable, // apb access phase
   input wire pwrite, // apb direction
   input wire [11:0] paddr, // apb byte address
   input wire [31:0] pwdata, // apb write data
   output reg [31:0] prdata, // apb read data
   output reg pready, // apb ready
   output reg pslverr, // apb error, unmapped address
   input wire [CW-1:0] count, // shared counter value
   input wire count_tick, // counter advanced this cycle
   input wire overflow, // counter overflow pulse
   input wire counter_halt_bit, // counter stopped
   input wire [1:0] channel_pin_in, // pin levels
   output reg [1:0] channel_pin_out, // channel output levels
   output reg [1:0] channel_pin_oe, // timer owns the pin
   output reg [1:0] channel_irq // flag and enable per channel
);

// ----------------------------------------------------------------
// decode helpers
// ----------------------------------------------------------------
// capture edge match for a select code
function edge_hit;
   input [1:0] els;
   input prev;
   input cur;
   begin
      edge_hit = ((els == `TCCC_ELS_RISE) && !prev && cur) ||
                 ((els == `TCCC_ELS_FALL) && prev && !cur) ||
                 ((els == `TCCC_ELS_BOTH) && (prev != cur));
   end
endfunction

// next pin level on a compare match
function cmp_level;
   input [1:0] els;
   input cur;
   begin
      case (els)
         `TCCC_ELS_RISE: cmp_level = ~cur;
         `TCCC_ELS_FALL: cmp_level = 1'b0;
         `TCCC_ELS_BOTH: cmp_level = 1'b1;
         default: cmp_level = cur;
      endcase
   end
endfunction

// ----------------------------------------------------------------
// state
// ----------------------------------------------------------------
reg [7:0] ctrl0_r;
reg [7:0] ctrl1_r;
reg [1:0] flag_armed_r; // control read seen with flag set
reg [1:0] cap_block_r; // high byte read, awaiting low
reg [1:0] cmp_block_r; // high byte written, awaiting low
reg [7:0] hi_buf0_r; // pending high byte per channel
reg [7:0] hi_buf1_r;
reg [1:0] pin_prev_r; // pin sample for edge detect
reg [1:0] full_r; // full-duty state latched per period
reg buf_sel_r; // buffered pair: channel now in control
reg buf_pend_r; // buffered pair: low byte written on either channel
reg [1:0] match_prev_r; // compare matched since the last count tick

wire [CW-1:0] val0;
wire [CW-1:0] val1;
reg [1:0] mem_we;
reg [CW-1:0] mem_wd0;
reg [CW-1:0] mem_wd1;

wire access = psel && penable;
wire wr = access && pwrite;
wire rd = access && !pwrite;
wire buffered = ctrl0_r[`TCCC_B_MSB];

// ----------------------------------------------------------------
// channel value store
// ----------------------------------------------------------------
tccc_value_mem #(.DW(CW)) u_mem
(
   .pclk(pclk),
   .we(mem_we),
   .wd0(mem_wd0),
   .wd1(mem_wd1),
   .rd0(val0),
   .rd1(val1)
);

// ----------------------------------------------------------------
// per-channel mode decode
// ----------------------------------------------------------------
wire [1:0] els0 = {ctrl0_r[`TCCC_B_ELSHI], ctrl0_r[`TCCC_B_ELSLO]};
wire [1:0] els1 = {ctrl1_r[`TCCC_B_ELSHI], ctrl1_r[`TCCC_B_ELSLO]};
// channel 1 is disabled while the pair is buffered
wire [1:0] en = {(els1 != `TCCC_ELS_OFF) && !buffered,
                 els0 != `TCCC_ELS_OFF}; // RULE4 RULE18
wire [1:0] msa = {ctrl1_r[`TCCC_B_MSA], ctrl0_r[`TCCC_B_MSA]};
wire [1:0] is_cap = en & ~msa & {1'b1, ~buffered}; // RULE19
wire [1:0] is_cmp = en & ~is_cap;
wire [1:0] ovt = {ctrl1_r[`TCCC_B_OVT], ctrl0_r[`TCCC_B_OVT]};
wire [1:0] fdf = {ctrl1_r[`TCCC_B_FULL], ctrl0_r[`TCCC_B_FULL]};

// captures stall while counter halted or high byte pending
wire [1:0] cap_ev;
assign cap_ev[0] = is_cap[0] && !counter_halt_bit && !cap_block_r[0] &&
   edge_hit(els0, pin_prev_r[0], channel_pin_in[0]); // RULE2 RULE14
assign cap_ev[1] = is_cap[1] && !counter_halt_bit && !cap_block_r[1] &&
   edge_hit(els1, pin_prev_r[1], channel_pin_in[1]); // RULE2 RULE14

// compare value: channel 0 uses the active buffered word
wire [CW-1:0] cmp_val0 = (buffered && buf_sel_r) ? val1 : val0;
wire [1:0] match_now = {count == val1, count == cmp_val0};
// one match per counter value, not one per bus clock
wire [1:0] cmp_ev = is_cmp & ~cmp_block_r & match_now &
   (~match_prev_r | {2{count_tick}}); // RULE15 RULE16

// overflow toggling only in compare mode
wire [1:0] ovf_act = is_cmp & ovt & {2{overflow}}; // RULE8 RULE9
// full duty only when overflow toggle is set
wire [1:0] full_eff = full_r & ovt; // RULE11 RULE20

// ----------------------------------------------------------------
// apb decode and value-register access
// ----------------------------------------------------------------
wire hit_c0 = paddr == `TCCC_OFS_CTRL0;
wire hit_h0 = paddr == `TCCC_OFS_HI0;
wire hit_l0 = paddr == `TCCC_OFS_LO0;
wire hit_c1 = paddr == `TCCC_OFS_CTRL1;
wire hit_h1 = paddr == `TCCC_OFS_HI1;
wire hit_l1 = paddr == `TCCC_OFS_LO1;
wire hit_st = paddr == `TCCC_OFS_STAT;
wire mapped = hit_c0 | hit_h0 | hit_l0 | hit_c1 | hit_h1 | hit_l1 |
   hit_st;

// store writes: low byte commits the pending high byte
always @*
begin
   mem_we = 2'b00;
   mem_wd0 = val0;
   mem_wd1 = val1;
   if (cap_ev[0])
   begin
      mem_we[0] = 1'b1;
      mem_wd0 = count;
   end
   else if (wr && pready && hit_l0)
   begin
      mem_we[0] = 1'b1; // RULE13
      mem_wd0 = {hi_buf0_r, pwdata[7:0]};
   end
   if (cap_ev[1])
   begin
      mem_we[1] = 1'b1;
      mem_wd1 = count;
   end
   else if (wr && pready && hit_l1)
   begin
      mem_we[1] = 1'b1; // RULE13
      mem_wd1 = {hi_buf1_r, pwdata[7:0]};
   end
end

// ----------------------------------------------------------------
// apb slave: one wait state, answer in second access cycle
// ----------------------------------------------------------------
always @(posedge pclk or negedge presetn)
begin
   if (!presetn)
   begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
   end
   else
   begin
      pready <= access && !pready;
      pslverr <= access && !pready && !mapped;
      prdata <= 32'h00000000;
      if (access && !pready && !pwrite)
      begin
         case (1'b1)
            hit_c0: prdata <= {24'h000000, ctrl0_r};
            hit_h0: prdata <= {24'h000000, val0[15:8]};
            hit_l0: prdata <= {24'h000000, val0[7:0]};
            hit_c1: prdata <= {24'h000000, ctrl1_r};
            hit_h1: prdata <= {24'h000000, val1[15:8]};
            hit_l1: prdata <= {24'h000000, val1[7:0]};
            hit_st: prdata <= {29'h00000000, buf_sel_r, full_r};
            default: prdata <= 32'h00000000;
         endcase
      end
   end
end

// ----------------------------------------------------------------
// control registers, flags and byte interlocks
// ----------------------------------------------------------------
// software owns the mode bits; mode changes assume a halted,
// cleared counter, so no glitch handling is done here
always @(posedge pclk or negedge presetn)
begin
   if (!presetn)
   begin
      ctrl0_r <= `TCCC_CTRL_RST; // RULE6 RULE9 RULE19
      ctrl1_r <= `TCCC_CTRL_RST; // RULE6
      flag_armed_r <= 2'b00;
      cap_block_r <= 2'b00;
      cmp_block_r <= 2'b00;
      hi_buf0_r <= 8'h00;
      hi_buf1_r <= 8'h00;
   end
   else
   begin
      if (rd && pready && hit_c0 && ctrl0_r[`TCCC_B_FLAG])
      begin
         flag_armed_r[0] <= 1'b1;
      end
      if (rd && pready && hit_c1 && ctrl1_r[`TCCC_B_FLAG])
      begin
         flag_armed_r[1] <= 1'b1;
      end
      // high byte read latches the capture interlock
      if (rd && pready && hit_h0 && is_cap[0])
      begin
         cap_block_r[0] <= 1'b1; // RULE14
      end
      if (rd && pready && hit_l0)
      begin
         cap_block_r[0] <= 1'b0;
      end
      if (rd && pready && hit_h1 && is_cap[1])
      begin
         cap_block_r[1] <= 1'b1; // RULE14
      end
      if (rd && pready && hit_l1)
      begin
         cap_block_r[1] <= 1'b0;
      end
      if (wr && pready && hit_h0)
      begin
         hi_buf0_r <= pwdata[7:0];
         cmp_block_r[0] <= msa[0] | buffered; // RULE15
      end
      if (wr && pready && hit_l0)
      begin
         cmp_block_r[0] <= 1'b0;
      end
      if (wr && pready && hit_h1)
      begin
         hi_buf1_r <= pwdata[7:0];
         cmp_block_r[1] <= msa[1] | buffered; // RULE15
      end
      if (wr && pready && hit_l1)
      begin
         cmp_block_r[1] <= 1'b0;
      end
      // control writes; flag only clears on armed write of 0
      if (wr && pready && hit_c0)
      begin
         ctrl0_r[6:0] <= pwdata[6:0];
         flag_armed_r[0] <= 1'b0;
         if (flag_armed_r[0] && !pwdata[`TCCC_B_FLAG])
         begin
            ctrl0_r[`TCCC_B_FLAG] <= 1'b0; // RULE17
         end
      end
      // channel 1 control is frozen while buffered
      if (wr && pready && hit_c1 && !buffered)
      begin
         ctrl1_r[6:0] <= {pwdata[6], 1'b0, pwdata[4:0]}; // RULE18
         flag_armed_r[1] <= 1'b0;
         if (flag_armed_r[1] && !pwdata[`TCCC_B_FLAG])
         begin
            ctrl1_r[`TCCC_B_FLAG] <= 1'b0; // RULE17
         end
      end
      // a new event sets the flag and disarms the clear
      if (cap_ev[0] | cmp_ev[0])
      begin
         ctrl0_r[`TCCC_B_FLAG] <= 1'b1; // RULE16
         flag_armed_r[0] <= 1'b0; // RULE17
      end
      if (cap_ev[1] | cmp_ev[1])
      begin
         ctrl1_r[`TCCC_B_FLAG] <= 1'b1; // RULE16
         flag_armed_r[1] <= 1'b0; // RULE17
      end
   end
end

// ----------------------------------------------------------------
// buffered pair selection and period-latched full duty
// ----------------------------------------------------------------
always @(posedge pclk or negedge presetn)
begin
   if (!presetn)
   begin
      buf_sel_r <= 1'b0;
      buf_pend_r <= 1'b0;
      full_r <= 2'b00;
      pin_prev_r <= 2'b00;
      match_prev_r <= 2'b00;
   end
   else
   begin
      pin_prev_r <= channel_pin_in;
      // the tick cycle's own match is remembered, else it fires twice
      match_prev_r <= count_tick ? match_now : (match_now | match_prev_r);
      // a low-byte write to either channel swaps the active word at overflow
      if (wr && pready && (hit_l0 || hit_l1))
      begin
         buf_pend_r <= 1'b1;
         buf_sel_r <= buf_sel_r;
      end
      if (!buffered)
      begin
         buf_sel_r <= 1'b0;
         buf_pend_r <= 1'b0;
      end
      else if (overflow && buf_pend_r)
      begin
         buf_sel_r <= ~buf_sel_r;
         buf_pend_r <= 1'b0;
      end
      // full duty sampled only at period boundary
      if (overflow)
      begin
         full_r <= fdf; // RULE12
      end
   end
end

// ----------------------------------------------------------------
// pin output levels
// ----------------------------------------------------------------
// while disabled the level is preset from mode bit a, and that
// preset is what appears on the pin once the channel is enabled in compare mode
always @(posedge pclk or negedge presetn)
begin
   if (!presetn)
   begin
      channel_pin_out <= 2'b11;
      channel_pin_oe <= 2'b00;
      channel_irq <= 2'b00;
   end
   else
   begin
      channel_pin_oe <= is_cmp; // RULE4 RULE5 RULE18
      channel_irq <= {ctrl1_r[`TCCC_B_FLAG] & ctrl1_r[`TCCC_B_IE],
                      ctrl0_r[`TCCC_B_FLAG] & ctrl0_r[`TCCC_B_IE]};
      if (!en[0])
      begin
         channel_pin_out[0] <= ~msa[0]; // RULE4
      end
      else if (is_cmp[0] && full_eff[0])
      begin
         channel_pin_out[0] <= 1'b1; // RULE11
      end
      else if (ovf_act[0])
      begin
         channel_pin_out[0] <= ~channel_pin_out[0]; // RULE8 RULE10
      end
      else if (cmp_ev[0])
      begin
         channel_pin_out[0] <= cmp_level(els0, channel_pin_out[0]); // RULE3
      end
      if (!en[1])
      begin
         channel_pin_out[1] <= ~msa[1]; // RULE4
      end
      else if (is_cmp[1] && full_eff[1])
      begin
         channel_pin_out[1] <= 1'b1; // RULE11
      end
      else if (ovf_act[1])
      begin
         channel_pin_out[1] <= ~channel_pin_out[1]; // RULE8 RULE10
      end
      else if (cmp_ev[1])
      begin
         channel_pin_out[1] <= cmp_level(els1, channel_pin_out[1]); // RULE3
      end
   end
end

endmodule

// >>> tb/tccc_pin_model.sv
// pin-side model of the external sources on the channel pins
`timescale 1ns/1ps
module tccc_pin_model
(
   input wire pclk, // clock
   input wire [1:0] oe, // timer drives pin
   input wire [1:0] out, // timer level
   input wire [1:0] ext_en, // source drives pin
   input wire [1:0] ext_lvl, // source level
   output wire [1:0] pin // resolved level
);
   reg [1:0] float_r = 2'h0;
   // an undriven pin wanders so a stale level never looks valid
   always @(posedge pclk)
      float_r <= ~float_r;
   // source level only moves when the bench moves it
   assign pin = (oe & out) | (~oe & ext_en & ext_lvl)
      | (~oe & ~ext_en & float_r);
endmodule

// >>> tb/tccc_checker.sv
// concurrent checks on the capture/compare block ports
`timescale 1ns/1ps
module tccc_checker
(
   input wire pclk, // clock
   input wire presetn, // reset
   input wire psel, // select
   input wire penable, // access
   input wire pwrite, // direction
   input wire [11:0] paddr, // address
   input wire [31:0] pwdata, // write data
   input wire pready, // ready
   input wire overflow, // overflow pulse
   input wire [1:0] channel_pin_out, // pin level
   input wire [1:0] channel_pin_oe // pin owner
);
   // ------
   // shadow of channel 0 control
   // ------
   reg [5:0] c0_r;
   wire wr0 = psel && penable && pready && pwrite && paddr == 12'h000;
   wire cmp = c0_r[5:4] == 2'b01 && c0_r[3:2] != 2'h0;
   // only completed bus writes move the mode bits
   always @(posedge pclk or negedge presetn)
      if (!presetn)
         c0_r <= 6'h00;
      else if (wr0)
         c0_r <= pwdata[5:0];
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_reset_off: assert property ($rose(presetn) |-> channel_pin_oe == 2'h0)
      else $error("pin driven right after reset");
   a_preset_high: assert property (wr0 && pwdata[5:2] == 4'h0 |-> ##[1:2]
      channel_pin_out[0] && !channel_pin_oe[0]) else $error("preset high");
   a_preset_low: assert property (wr0 && pwdata[5:2] == 4'h4 |-> ##[1:2]
      !channel_pin_out[0] && !channel_pin_oe[0]) else $error("preset low");
   a_cmp_drives: assert property (wr0 && pwdata[5:4] == 2'b01 &&
      pwdata[3:2] != 2'h0 |-> ##[1:2] channel_pin_oe[0])
      else $error("compare pin not driven");
   a_cap_released: assert property (wr0 && pwdata[5:4] == 2'b00
      |-> ##[1:2] !channel_pin_oe[0]) else $error("capture pin driven");
   a_buf_frees: assert property (wr0 && pwdata[5]
      |-> ##[1:2] !channel_pin_oe[1]) else $error("pin 1 kept");
   a_ovf_toggle: assert property (overflow && cmp && c0_r[1:0] == 2'b01
      && !wr0 |=> channel_pin_out[0] != $past(channel_pin_out[0]))
      else $error("no toggle on overflow");
   a_full_high: assert property (overflow && cmp && c0_r[1:0] == 2'b11
      |-> ##2 channel_pin_out[0] [*2]) else $error("full duty lost");
   a_cap_ignores: assert property (overflow && c0_r[5:4] == 2'b00 && !wr0
      |=> $stable(channel_pin_out[0])) else $error("capture pin moved");
endmodule
bind tccc_top tccc_checker u_chk
(
   .pclk(pclk),
   .presetn(presetn),
   .psel(psel),
   .penable(penable),
   .pwrite(pwrite),
   .paddr(paddr),
   .pwdata(pwdata),
   .pready(pready),
   .overflow(overflow),
   .channel_pin_out(channel_pin_out),
   .channel_pin_oe(channel_pin_oe)
);

// >>> tb/testbench.sv
// self-checking bench for the capture/compare block
`timescale 1ns/1ps
`include "tccc_defs.vh"
module testbench;
   reg pclk = 1'b0;
   reg presetn = 1'b0;
   reg psel = 1'b0;
   reg penable = 1'b0;
   reg pwrite = 1'b0;
   reg [11:0] paddr = 12'h000;
   reg [31:0] pwdata = 32'h0;
   reg [15:0] count = 16'h0000;
   reg count_tick = 1'b0;
   reg overflow = 1'b0;
   reg [1:0] ext_lvl = 2'h0;
   reg halt = 1'b0;
   wire [1:0] irq;
   wire [31:0] prdata;
   wire pready;
   wire pslverr;
   wire [1:0] pin_out;
   wire [1:0] pin_oe;
   wire [1:0] pin_in;
   reg [31:0] rd;
   reg er;
   reg [15:0] v;
   reg [1:0] e;
   integer err_total = 0;
   integer check_count = 0;
   // ------
   // clock, design and pin model
   // ------
   always #5 pclk = ~pclk;
   tccc_top i_dut
   (
      .pclk(pclk),
      .presetn(presetn),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .prdata(prdata),
      .pready(pready),
      .pslverr(pslverr),
      .count(count),
      .count_tick(count_tick),
      .overflow(overflow),
      .counter_halt_bit(halt),
      .channel_pin_in(pin_in),
      .channel_pin_out(pin_out),
      .channel_pin_oe(pin_oe),
      .channel_irq(irq)
   );
   tccc_pin_model i_pins
   (
      .pclk(pclk),
      .oe(pin_oe),
      .out(pin_out),
      .ext_en(2'h1),
      .ext_lvl(ext_lvl),
      .pin(pin_in)
   );
   // compare and count
   task chk(input [31:0] got, input [31:0] exp);
      begin
         check_count = check_count + 1;
         if (got !== exp)
         begin
            err_total = err_total + 1;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
         end
      end
   endtask
   // one apb transfer, held until ready is sampled high
   task apb(input w, input [11:0] a, input [7:0] d);
      integer n;
      begin
         n = 0;
         psel <= 1'b1;
         pwrite <= w;
         paddr <= a;
         pwdata <= {24'h000000, d};
         @(posedge pclk);
         penable <= 1'b1;
         // no cycle count assumed; only the watchdog ends a wait
         do
         begin
            @(posedge pclk);
            n = n + 1;
         end
         while (pready !== 1'b1);
         chk(n, 2); // one wait state, then ready
         rd = prdata;
         er = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
         // second idle edge lets registered outputs settle
         repeat (2) @(posedge pclk);
      end
   endtask
   task wr(input [11:0] a, input [7:0] d);
      apb(1'b1, a, d);
   endtask
   task rdc(input [11:0] a, input [7:0] x);
      begin
         apb(1'b0, a, 8'h00);
         chk(rd, {24'h000000, x});
      end
   endtask
   // value read, high byte first as the interlock wants
   task rdv;
      begin
         rdc(`TCCC_OFS_HI0, v[15:8]);
         rdc(`TCCC_OFS_LO0, v[7:0]);
      end
   endtask
   // counter step, optionally with overflow
   task cnt(input [15:0] c, input ov);
      begin
         count <= c;
         count_tick <= 1'b1;
         overflow <= ov;
         @(posedge pclk);
         count_tick <= 1'b0;
         overflow <= 1'b0;
         repeat (3) @(posedge pclk);
      end
   endtask
   task final_report;
      begin
         $display("checks %0d errors %0d", check_count, err_total);
         if (err_total == 0 && check_count > 0)
            $display("verification passed");
         else
            $display("verification failed");
         $finish;
      end
   endtask
   // ------
   // test sequence
   // ------
   initial
   begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      chk(pin_oe, 2'h0);
      chk(pin_out, 2'h3);
      rdc(`TCCC_OFS_CTRL0, 8'h00);
      apb(1'b0, 12'h01C, 8'h00);
      chk(er, 1'b1);
      chk(rd, 32'h0);
      wr(`TCCC_OFS_HI0, 8'h00);
      wr(`TCCC_OFS_LO0, 8'h40);
      rdc(`TCCC_OFS_HI0, 8'h00);
      rdc(`TCCC_OFS_LO0, 8'h40);
      for (e = 1; e != 0; e = e + 1)
      begin
         wr(`TCCC_OFS_CTRL0, 8'h10);
         chk(pin_out[0], 1'b0);
         wr(`TCCC_OFS_CTRL0, {4'h1, e, 2'h0});
         chk(pin_oe[0], 1'b1);
         chk(pin_out[0], 1'b0);
         cnt(16'h0040, 1'b0);
         chk(pin_out[0], e != 2'h2);
         rdc(`TCCC_OFS_CTRL0, {4'h9, e, 2'h0});
         wr(`TCCC_OFS_CTRL0, {4'h1, e, 2'h0});
         rdc(`TCCC_OFS_CTRL0, {4'h1, e, 2'h0});
         cnt(16'h0000, 1'b0);
      end
      wr(`TCCC_OFS_CTRL0, 8'h14);
      wr(`TCCC_OFS_HI0, 8'h00);
      cnt(16'h0040, 1'b0);
      chk(pin_out[0], 1'b1);
      rdc(`TCCC_OFS_CTRL0, 8'h14);
      wr(`TCCC_OFS_LO0, 8'h40);
      cnt(16'h0000, 1'b0);
      cnt(16'h0040, 1'b0);
      chk(pin_out[0], 1'b0);
      wr(`TCCC_OFS_CTRL0, 8'h15);
      cnt(16'h0040, 1'b1);
      chk(pin_out[0], 1'b1);
      cnt(16'h0100, 1'b1);
      chk(pin_out[0], 1'b0);
      wr(`TCCC_OFS_CTRL0, 8'h14);
      cnt(16'h0101, 1'b1);
      chk(pin_out[0], 1'b0);
      wr(`TCCC_OFS_CTRL0, 8'h17);
      chk(pin_out[0], 1'b0);
      cnt(16'h0102, 1'b1);
      chk(pin_out[0], 1'b1);
      cnt(16'h0040, 1'b0);
      chk(pin_out[0], 1'b1);
      wr(`TCCC_OFS_CTRL0, 8'h15);
      chk(pin_out[0], 1'b1);
      wr(`TCCC_OFS_CTRL0, 8'h14);
      cnt(16'h0000, 1'b0);
      cnt(16'h0040, 1'b0);
      wr(`TCCC_OFS_CTRL0, 8'h16);
      cnt(16'h0104, 1'b1);
      chk(pin_out[0], 1'b0);
      rdc(`TCCC_OFS_STAT, 8'h01);
      v = 16'h0040;
      for (e = 1; e != 0; e = e + 1)
      begin
         wr(`TCCC_OFS_CTRL0, 8'h00);
         ext_lvl <= 2'h0;
         repeat (2) @(posedge pclk);
         halt <= 1'b1;
         wr(`TCCC_OFS_CTRL0, {4'h0, e, 2'h1});
         halt <= 1'b0;
         chk(pin_oe[0], 1'b0);
         cnt(16'h1234, 1'b1);
         ext_lvl <= 2'h1;
         repeat (3) @(posedge pclk);
         if (e != 2'h2)
            v = 16'h1234;
         rdv;
         cnt(16'h2345, 1'b0);
         ext_lvl <= 2'h0;
         repeat (3) @(posedge pclk);
         if (e != 2'h1)
            v = 16'h2345;
         rdv;
      end
      apb(1'b0, `TCCC_OFS_HI0, 8'h00);
      cnt(16'h3456, 1'b0);
      ext_lvl <= 2'h1;
      repeat (3) @(posedge pclk);
      rdv;
      cnt(16'h4567, 1'b0);
      ext_lvl <= 2'h0;
      repeat (3) @(posedge pclk);
      v = 16'h4567;
      rdv;
      // a halted counter must not capture an active edge
      halt <= 1'b1;
      cnt(16'h5678, 1'b0);
      ext_lvl <= 2'h1;
      repeat (3) @(posedge pclk);
      halt <= 1'b0;
      rdv;
      wr(`TCCC_OFS_CTRL1, 8'h14);
      chk(pin_oe[1], 1'b1);
      wr(`TCCC_OFS_CTRL0, 8'h24);
      chk(pin_oe, 2'h1);
      wr(`TCCC_OFS_CTRL0, 8'h64);
      chk(irq, 2'h1);
      final_report;
   end
   // a hang ends the run well past the expected few hundred cycles
   initial
   begin
      #100000;
      $display("[ERR] %0t timeout", $time);
      err_total = err_total + 1;
      final_report;
   end
endmodule
